/* File: verilog/serial_frame_checksum_inserter.v */
// Streaming checksum inserter for outgoing read-result frames
`timescale 1ns/1ps
`include "frame_check_defs.vh"
module serial_frame_checksum_inserter
(
	input  wire       core_clk,
	input  wire       rst_n,
	input  wire       checksum_enable,
	input  wire       plc_link_mode,
	input  wire       frame_is_command,
	input  wire       in_valid,
	input  wire [7:0] in_data,
	input  wire       in_head,
	input  wire       in_delim,
	output wire       in_ready,
	output reg        out_valid,
	output reg  [7:0] out_data,
	input  wire       out_ready
);
	// ==================================================================
	// Reset release
	reg        rst_meta_q;
	reg        rst_sync_q;
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ==================================================================
	// Frame state
	// Idle and body share the default branch: both accept stream bytes
	localparam [2:0] ST_IDLE  = `ST_IDLE;
	localparam [2:0] ST_BODY  = `ST_BODY;
	localparam [2:0] ST_HI    = `ST_HI;
	localparam [2:0] ST_LO    = `ST_LO;
	localparam [2:0] ST_DELIM = `ST_DELIM;

	// Registers and their next values
	reg  [2:0] state_q;
	reg  [2:0] state_d;
	reg  [7:0] sum_q;
	reg  [7:0] sum_d;
	reg  [7:0] delim_q;
	reg  [7:0] delim_d;
	reg        add_q;
	reg        add_d;
	reg        out_valid_d;
	reg  [7:0] out_data_d;

	// Checksum characters and handshake terms
	wire [7:0] hi_char;
	wire [7:0] lo_char;
	wire       slot_free;
	wire       inserting;
	wire       take;

	// ==================================================================
	// Hex encoding of the running sum
	// Both digits are decoded all the time; the state picks which one leaves.
	// The sum is frozen once the delimiter is taken, so both digits agree.
	// encode both nibbles
	hex_char_encoder u_hi
	(
		.nibble (sum_q[7:4]),
		.ascii  (hi_char)
	);

	hex_char_encoder u_lo
	(
		.nibble (sum_q[3:0]),
		.ascii  (lo_char)
	);

	// ==================================================================
	// Input handshake
	// The output register is the only storage, so input waits for it.
	// Input also stalls for the whole insertion: the checksum chars and the
	// held delimiter use the same output slot, and a byte taken then is lost.
	// in_ready is combinational on purpose: a registered ready would need a
	// skid register, which the stream does not have room for.
	assign slot_free = !out_valid || out_ready;
	assign inserting = (state_q == ST_HI) || (state_q == ST_LO) || (state_q == ST_DELIM);
	assign in_ready  = slot_free && !inserting && rst_sync_q;
	assign take      = in_valid && in_ready;

	// ==================================================================
	// Next-state logic
	// Defaults hold every register; the output byte drops once consumed.
	always @*
	begin
		state_d     = state_q;
		sum_d       = sum_q;
		delim_d     = delim_q;
		add_d       = add_q;
		out_valid_d = out_valid && !out_ready;
		out_data_d  = out_data;
		case (state_q)
			ST_HI:
			begin
				// High-order digit leaves first
				if (slot_free)
				begin
					out_valid_d = 1'b1;
					out_data_d  = hi_char;
					state_d     = ST_LO;
				end
			end
			ST_LO:
			begin
				// Low-order digit follows at once
				if (slot_free)
				begin
					out_valid_d = 1'b1;
					out_data_d  = lo_char;
					state_d     = ST_DELIM;
				end
			end
			ST_DELIM:
			begin
				if (slot_free)
				begin
					out_valid_d = 1'b1;
					out_data_d  = delim_q;
					state_d     = ST_IDLE;
				end
			end
			default:
			begin
				// Stream bytes pass through with one cycle of latency
				if (take)
				begin
					out_valid_d = 1'b1;
					out_data_d  = in_data;
					if (in_head)
					begin
						sum_d   = `XOR_INIT;
						add_d   = checksum_enable && !frame_is_command && !plc_link_mode;
						state_d = ST_BODY;
					end
					else if (in_delim)
					begin
						// Hold delimiter back until checksum chars are sent
						if (add_q)
						begin
							out_valid_d = 1'b0;
							delim_d     = in_data;
							state_d     = ST_HI;
						end
						else
							state_d = ST_IDLE;
					end
					else
					begin
						sum_d = sum_q ^ in_data;
					end
				end
			end
		endcase
	end

	// ==================================================================
	// Registers
	// Reset branch loads constants only; the synchronised copy of reset
	// keeps the stream idle for two more edges so nothing is taken half-reset.
	// Limitation: a frame without a header reuses the last latched mode.
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q   <= ST_IDLE;
			sum_q     <= `XOR_INIT;
			delim_q   <= `XOR_INIT;
			add_q     <= 1'b0;
			out_valid <= 1'b0;
			out_data  <= `XOR_INIT;
		end
		else if (!rst_sync_q)
		begin
			state_q   <= ST_IDLE;
			out_valid <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			sum_q     <= sum_d;
			delim_q   <= delim_d;
			add_q     <= add_d;
			out_valid <= out_valid_d;
			out_data  <= out_data_d;
		end
	end
endmodule // serial_frame_checksum_inserter

/* File: verilog/frame_check_defs.vh */
// Constants for the serial frame checksum inserter
`ifndef FRAME_CHECK_DEFS_VH
`define FRAME_CHECK_DEFS_VH
`define XOR_INIT        8'h00
`define ASCII_ZERO      8'h30
`define ASCII_A_MINUS10 8'h37
`define NIBBLE_TEN      4'hA
`define ST_IDLE         3'h0
`define ST_HEAD         3'h1
`define ST_BODY         3'h2
`define ST_HI           3'h3
`define ST_LO           3'h4
`define ST_DELIM        3'h5
`endif

/* File: verilog/hex_char_encoder.v */
// Nibble to ASCII hexadecimal character encoder
`timescale 1ns/1ps
`include "frame_check_defs.vh"
module hex_char_encoder
(
	input  wire [3:0] nibble,
	output wire [7:0] ascii
);
	assign ascii = (nibble < `NIBBLE_TEN) ? ({4'h0, nibble} + `ASCII_ZERO) : ({4'h0, nibble} + `ASCII_A_MINUS10);
endmodule // hex_char_encoder

/* File: bench/host_rx.sv */
// Host model that drains the output stream with random stalls
`timescale 1ns/1ps
module host_rx(input logic c,output logic r=0);
// Random back-pressure, about one stall in four
always @(negedge c)r<=$urandom%4!=0;
endmodule // host_rx

/* File: bench/frame_chk_sva.sv */
// Checker for the checksum inserter ports
`timescale 1ns/1ps
module frame_chk_sva(input logic core_clk,rst_n,checksum_enable,plc_link_mode,frame_is_command,
in_valid,in_head,in_delim,in_ready,out_valid,out_ready,input logic [7:0] in_data,out_data);
logic e_q;
wire v=out_valid,r=out_ready,t=in_valid&&in_ready,d=t&&in_delim;
always_ff @(posedge core_clk or negedge rst_n)if(!rst_n)e_q<=1'h0;
else if(t&&in_head)e_q<=checksum_enable&&!plc_link_mode&&!frame_is_command;
default clocking @(posedge core_clk);endclocking
default disable iff(!rst_n);
property p_hv;v&&!r|=>v;endproperty
a_hv:assert property(p_hv)else $error("drop");
property p_hd;v&&!r|=>$stable(out_data);endproperty
a_hd:assert property(p_hd)else $error("hold");
property p_rf;v&&!r|->!in_ready;endproperty
a_rf:assert property(p_rf)else $error("take");
property p_lt;t&&!(in_delim&&e_q)|=>v;endproperty
a_lt:assert property(p_lt)else $error("late");
property p_ec;t&&!in_delim|=>out_data==$past(in_data);endproperty
a_ec:assert property(p_ec)else $error("echo");
property p_nc;d&&!e_q|=>out_data==$past(in_data);endproperty
a_nc:assert property(p_nc)else $error("extra");
property p_gp;d&&e_q|=>!in_ready[*3];endproperty
a_gp:assert property(p_gp)else $error("gap");
property p_hx;d&&e_q&&r|->##[1:3]v&&out_data inside{[8'h30:8'h39],[8'h41:8'h46]};endproperty
a_hx:assert property(p_hx)else $error("hex");
endmodule // frame_chk_sva
bind serial_frame_checksum_inserter frame_chk_sva u_sva(.core_clk(core_clk),.rst_n(rst_n),
.checksum_enable(checksum_enable),.plc_link_mode(plc_link_mode),.frame_is_command(frame_is_command),
.in_valid(in_valid),.in_head(in_head),.in_delim(in_delim),.in_ready(in_ready),.out_valid(out_valid),
.out_ready(out_ready),.in_data(in_data),.out_data(out_data));

/* File: bench/test_serial_frame_checksum_inserter.sv */
// Bench for the checksum inserter
`timescale 1ns/1ps
module test_serial_frame_checksum_inserter;
logic core_clk=0,rst_n=0,checksum_enable=0,plc_link_mode=0,frame_is_command=0,in_valid=0,in_head=0,in_delim=0;
logic in_ready,out_valid,out_ready,t;
logic [7:0] in_data=0,out_data,q[$];
int bad_count=0,compares=0,i;
serial_frame_checksum_inserter uut(.core_clk(core_clk),.rst_n(rst_n),.checksum_enable(checksum_enable),
.plc_link_mode(plc_link_mode),.frame_is_command(frame_is_command),.in_valid(in_valid),.in_data(in_data),
.in_head(in_head),.in_delim(in_delim),.in_ready(in_ready),.out_valid(out_valid),.out_data(out_data),
.out_ready(out_ready));
host_rx h(.c(core_clk),.r(out_ready));
initial forever #4 core_clk=~core_clk;
function logic [7:0] hx(logic [3:0] n);return n>9?8'h37+n:8'h30+n;endfunction
task chk(logic [7:0] g,e);compares++;
if(g!==e)begin bad_count++;$display("MISMATCH %0t got %h want %h",$time,g,e);end endtask
task stop_test;$display("%0d bad of %0d",bad_count,compares);
if(bad_count==0&&compares>0)$display("TB: PASS");else $display("TB: FAIL");$finish;endtask
// Hold a byte until it is taken
task put(logic [7:0] b,logic h,d);q.push_back(b);{in_valid,in_data,in_head,in_delim}={1'b1,b,h,d};
do begin #1 t=in_ready;@(negedge core_clk);end while(!t);endtask
task frame(logic e,p,f,int n);logic [7:0] s,b;s=0;{checksum_enable,plc_link_mode,frame_is_command}={e,p,f};
put(8'h02,1,0);repeat(n)begin b=8'($urandom);s^=b;put(b,0,0);end
if(e&&!p&&!f)begin q.push_back(hx(s[7:4]));q.push_back(hx(s[3:0]));end
put(8'h0D,0,1);endtask
// Worked example: body ABC123 folds to 70h, sent as 37h 30h
task known;{checksum_enable,plc_link_mode,frame_is_command}=3'b100;put(8'h02,1,0);
put(8'h41,0,0);put(8'h42,0,0);put(8'h43,0,0);put(8'h31,0,0);put(8'h32,0,0);put(8'h33,0,0);
q.push_back(8'h37);q.push_back(8'h30);put(8'h0D,0,1);endtask
always @(negedge core_clk)#2 if(out_valid&&out_ready)begin
if(q.size())chk(out_data,q.pop_front());
else begin bad_count++;$display("MISMATCH %0t byte not expected",$time);end end
initial begin repeat(9999)@(posedge core_clk);bad_count++;$display("MISMATCH %0t timeout",$time);stop_test;end
initial begin i=$urandom(32'h5AFCF7A3);repeat(10)@(negedge core_clk);rst_n=1;repeat(3)@(negedge core_clk);
known;$display("known done");
for(i=0;i<48;i++)begin frame(i[0],i[1]&i[2],i[2]&!i[1],i<4?0:$urandom%14);$display("f%0d",i);end
in_valid=0;repeat(40)@(negedge core_clk);chk(8'(q.size()),0);stop_test;end
endmodule // test_serial_frame_checksum_inserter
